// [logic/phsr_pkg.sv]
// constants of the hot-plug slot control and event status registers
// assumes one 20 MHz bridge clock and a byte-addressed config access port
package phsr_pkg;
   localparam logic [7:0] CTRL_OFFSET = 8'h70;
   localparam logic [7:0] STAT_OFFSET = 8'h72;
   localparam logic [15:0] CTRL_RESET = 16'h07c0;
   localparam logic [15:0] STAT_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WR_MASK = 16'h1fff;
   localparam logic [15:0] STAT_W1C_MASK = 16'h011f;
   // status bit positions
   localparam int ST_BUTTON = 0;
   localparam int ST_FAULT = 1;
   localparam int ST_LATCH = 2;
   localparam int ST_PRESENCE = 3;
   localparam int ST_CMD_DONE = 4;
   localparam int ST_LATCH_STATE = 5;
   localparam int ST_PRESENT = 6;
   localparam int ST_LINK = 8;
   // control bit positions
   localparam int CT_BUTTON_EN = 0;
   localparam int CT_FAULT_EN = 1;
   localparam int CT_LATCH_EN = 2;
   localparam int CT_PRESENCE_EN = 3;
   localparam int CT_CMD_DONE_EN = 4;
   localparam int CT_MASTER_EN = 5;
   localparam int CT_ALERT_LO = 6;
   localparam int CT_POWER_LAMP_LO = 8;
   localparam int CT_POWER_OFF = 10;
   localparam int CT_INTERLOCK = 11;
   localparam int CT_LINK_EN = 12;
   // indicator field codes
   localparam logic [1:0] LAMP_ON = 2'h1;
   localparam logic [1:0] LAMP_BLINK = 2'h2;
   localparam logic [1:0] LAMP_OFF = 2'h3;
   // cycles after reset before slot edges count as events
   localparam logic [1:0] SETTLE_CYCLES = 2'h3;
endpackage

// [logic/phsr_evt_if.sv]
// slot events and levels passed from the pin detector to the registers
// assumes both ends run on ref_clk
`timescale 1ns/1ps
interface phsr_evt_if;
   logic button_press;
   logic power_fault;
   logic latch_change;
   logic presence_change;
   logic cmd_done;
   logic link_change;
   logic latch_state;
   logic presence_state;
   modport src (output button_press, power_fault, latch_change,
      presence_change, cmd_done, link_change, latch_state, presence_state);
   modport dst (input button_press, power_fault, latch_change,
      presence_change, cmd_done, link_change, latch_state, presence_state);
endinterface

// [logic/phsr_events.sv]
// slot pin synchroniser and edge detector producing one-cycle events
// assumes slot pins are asynchronous and link_active is on ref_clk
`timescale 1ns/1ps
module phsr_events (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic attn_button_pin,
   input wire logic power_fault_pin,
   input wire logic latch_open_pin,
   input wire logic presence_pin,
   input wire logic cmd_done_pin,
   input wire logic link_active,
   phsr_evt_if.src evt
);
   // order: button, fault, latch, presence, command done
   logic [4:0] sync_a;
   logic [4:0] sync_b;
   logic [4:0] prev;
   logic link_prev;
   logic [1:0] settle;
   logic [1:0] next_settle;
   logic armed;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_a <= 5'h00;
         sync_b <= 5'h00;
         prev <= 5'h00;
         link_prev <= 1'b0;
         settle <= 2'h0;
      end else begin
         sync_a <= {cmd_done_pin, presence_pin, latch_open_pin,
            power_fault_pin, attn_button_pin};
         sync_b <= sync_a;
         prev <= sync_b;
         link_prev <= link_active;
         settle <= next_settle;
      end
   end

   always_comb begin
      armed = (settle == phsr_pkg::SETTLE_CYCLES);
      next_settle = armed ? settle : settle + 2'h1;
      evt.button_press = armed && sync_b[0] && !prev[0];
      evt.power_fault = armed && sync_b[1] && !prev[1];
      evt.latch_change = armed && (sync_b[2] != prev[2]);
      evt.presence_change = armed && (sync_b[3] != prev[3]);
      evt.cmd_done = armed && sync_b[4] && !prev[4];
      evt.link_change = armed && (link_active != link_prev);
      evt.latch_state = sync_b[2];
      evt.presence_state = sync_b[3];
   end
endmodule // phsr_events

// [logic/phsr_regs.sv]
// hot-plug slot control and event status registers of a root port
// assumes config accesses on ref_clk; slot pins arrive asynchronously
`timescale 1ns/1ps
module phsr_regs (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_wr_en,
   input wire logic cfg_rd_en,
   input wire logic [1:0] cfg_be,
   input wire logic [15:0] cfg_wdata,
   output logic [15:0] cfg_rdata,
   output logic cfg_rd_valid,
   input wire logic attn_button_pin,
   input wire logic power_fault_pin,
   input wire logic latch_open_pin,
   input wire logic presence_pin,
   input wire logic cmd_done_pin,
   input wire logic link_active,
   output logic alert_lamp_on,
   output logic alert_lamp_blink,
   output logic power_lamp_on,
   output logic power_lamp_blink,
   output logic slot_power_en,
   output logic interlock_engage,
   output logic slot_irq
);
   phsr_evt_if evt ();

   phsr_events u_events (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .attn_button_pin(attn_button_pin),
      .power_fault_pin(power_fault_pin),
      .latch_open_pin(latch_open_pin),
      .presence_pin(presence_pin),
      .cmd_done_pin(cmd_done_pin),
      .link_active(link_active),
      .evt(evt.src)
   );

   // byte enables to a 16-bit lane mask
   function automatic logic [15:0] lane_mask(input logic [1:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction

   logic [15:0] slot_control;
   logic [15:0] next_slot_control;
   logic [15:0] slot_event_status;
   logic [15:0] next_slot_event_status;
   logic [15:0] next_cfg_rdata;
   logic next_cfg_rd_valid;
   logic next_alert_lamp_on;
   logic next_alert_lamp_blink;
   logic next_power_lamp_on;
   logic next_power_lamp_blink;
   logic next_slot_power_en;
   logic next_interlock_engage;
   logic next_slot_irq;
   logic [15:0] wr_mask;
   logic [15:0] clr_vec;
   logic [15:0] set_vec;
   logic [15:0] enable_vec;
   logic [15:0] status_view;
   logic ctrl_hit;
   logic stat_hit;
   logic [1:0] alert_field;
   logic [1:0] power_field;

   always_comb begin
      wr_mask = lane_mask(cfg_be);
      ctrl_hit = cfg_addr == phsr_pkg::CTRL_OFFSET;
      stat_hit = cfg_addr == phsr_pkg::STAT_OFFSET;
      next_slot_control = slot_control;
      if (cfg_wr_en && ctrl_hit) begin
         next_slot_control = (slot_control
            & ~(wr_mask & phsr_pkg::CTRL_WR_MASK))
            | (cfg_wdata & wr_mask & phsr_pkg::CTRL_WR_MASK);
      end
      // only ones written clear; zeros leave flags alone
      clr_vec = 16'h0000;
      if (cfg_wr_en && stat_hit) begin
         clr_vec = cfg_wdata & wr_mask & phsr_pkg::STAT_W1C_MASK;
      end
      set_vec = 16'h0000;
      set_vec[phsr_pkg::ST_BUTTON] = evt.button_press;
      set_vec[phsr_pkg::ST_FAULT] = evt.power_fault;
      set_vec[phsr_pkg::ST_LATCH] = evt.latch_change;
      set_vec[phsr_pkg::ST_PRESENCE] = evt.presence_change;
      set_vec[phsr_pkg::ST_CMD_DONE] = evt.cmd_done;
      set_vec[phsr_pkg::ST_LINK] = evt.link_change;
      // a new event wins over a clear in the same cycle
      next_slot_event_status = (slot_event_status & ~clr_vec) | set_vec;
      // per-flag enables lined up with the flag positions
      enable_vec = 16'h0000;
      enable_vec[phsr_pkg::ST_BUTTON] =
         slot_control[phsr_pkg::CT_BUTTON_EN];
      enable_vec[phsr_pkg::ST_FAULT] =
         slot_control[phsr_pkg::CT_FAULT_EN];
      enable_vec[phsr_pkg::ST_LATCH] = slot_control[phsr_pkg::CT_LATCH_EN];
      enable_vec[phsr_pkg::ST_PRESENCE] =
         slot_control[phsr_pkg::CT_PRESENCE_EN];
      enable_vec[phsr_pkg::ST_CMD_DONE] =
         slot_control[phsr_pkg::CT_CMD_DONE_EN];
      enable_vec[phsr_pkg::ST_LINK] =
         slot_control[phsr_pkg::CT_LINK_EN];
      next_slot_irq = slot_control[phsr_pkg::CT_MASTER_EN]
         && |(slot_event_status & enable_vec);
      alert_field = slot_control[phsr_pkg::CT_ALERT_LO +: 2];
      power_field = slot_control[phsr_pkg::CT_POWER_LAMP_LO +: 2];
      next_alert_lamp_on = alert_field == phsr_pkg::LAMP_ON;
      next_alert_lamp_blink = alert_field == phsr_pkg::LAMP_BLINK;
      next_power_lamp_on = power_field == phsr_pkg::LAMP_ON;
      next_power_lamp_blink = power_field == phsr_pkg::LAMP_BLINK;
      next_slot_power_en =
         !slot_control[phsr_pkg::CT_POWER_OFF];
      next_interlock_engage =
         slot_control[phsr_pkg::CT_INTERLOCK];
      status_view = slot_event_status;
      status_view[phsr_pkg::ST_LATCH_STATE] = evt.latch_state;
      status_view[phsr_pkg::ST_PRESENT] = evt.presence_state;
      next_cfg_rd_valid = cfg_rd_en;
      next_cfg_rdata = 16'h0000;
      if (cfg_rd_en && ctrl_hit) begin
         next_cfg_rdata = slot_control;
      end else if (cfg_rd_en && stat_hit) begin
         next_cfg_rdata = status_view;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         slot_control <= phsr_pkg::CTRL_RESET;
         slot_event_status <= phsr_pkg::STAT_RESET;
         cfg_rdata <= 16'h0000;
         cfg_rd_valid <= 1'b0;
         alert_lamp_on <= 1'b0;
         alert_lamp_blink <= 1'b0;
         power_lamp_on <= 1'b0;
         power_lamp_blink <= 1'b0;
         slot_power_en <= 1'b0;
         interlock_engage <= 1'b0;
         slot_irq <= 1'b0;
      end else begin
         slot_control <= next_slot_control;
         slot_event_status <= next_slot_event_status;
         cfg_rdata <= next_cfg_rdata;
         cfg_rd_valid <= next_cfg_rd_valid;
         alert_lamp_on <= next_alert_lamp_on;
         alert_lamp_blink <= next_alert_lamp_blink;
         power_lamp_on <= next_power_lamp_on;
         power_lamp_blink <= next_power_lamp_blink;
         slot_power_en <= next_slot_power_en;
         interlock_engage <= next_interlock_engage;
         slot_irq <= next_slot_irq;
      end
   end

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_stat_wr;
      cfg_wr_en && cfg_addr == phsr_pkg::STAT_OFFSET;
   endsequence

   sequence s_w1c(int b);
      s_stat_wr ##0 cfg_be[b / 8] && cfg_wdata[b];
   endsequence

   sequence s_ctrl_wr;
      cfg_wr_en && cfg_addr == phsr_pkg::CTRL_OFFSET;
   endsequence

   property p_set(logic ev, int b);
      ev |=> slot_event_status[b];
   endproperty

   property p_clear(logic ev, int b);
      s_w1c(b) ##0 !ev |=> !slot_event_status[b];
   endproperty

   AST_BUTTON_SET: assert property (p_set(evt.button_press, 0))
      else $error("button flag not set");
   AST_BUTTON_CLR: assert property (p_clear(evt.button_press, 0))
      else $error("button flag not cleared");
   AST_FAULT_SET: assert property (p_set(evt.power_fault, 1))
      else $error("power fault flag not set");
   AST_FAULT_CLR: assert property (p_clear(evt.power_fault, 1))
      else $error("power fault flag not cleared");
   AST_LATCH_SET: assert property (p_set(evt.latch_change, 2))
      else $error("latch flag not set");
   AST_PRESENCE_SET: assert property (p_set(evt.presence_change, 3))
      else $error("presence flag not set");
   AST_CMD_SET: assert property (p_set(evt.cmd_done, 4))
      else $error("command flag not set");
   AST_LINK_CLR: assert property (p_clear(evt.link_change, 8))
      else $error("link flag not cleared");

   // remaining set and clear paths, flags holding without cause
   AST_LATCH_CLR: assert property (p_clear(evt.latch_change, 2))
      else $error("latch flag not cleared");
   AST_PRES_CLR: assert property (p_clear(evt.presence_change, 3))
      else $error("presence flag not cleared");
   AST_CMD_CLR: assert property (p_clear(evt.cmd_done, 4))
      else $error("command flag not cleared");
   AST_LINK_SET: assert property (p_set(evt.link_change, 8))
      else $error("link flag not set");
   AST_BUTTON_HOLD: assert property (slot_event_status[0]
      && !(cfg_wr_en && cfg_addr == phsr_pkg::STAT_OFFSET)
      |=> slot_event_status[0])
      else $error("button flag lost without clear");
   AST_BUTTON_QUIET: assert property (!slot_event_status[0]
      && !evt.button_press |=> !slot_event_status[0])
      else $error("button flag set without event");
   AST_LINK_QUIET: assert property (!slot_event_status[8]
      && !evt.link_change |=> !slot_event_status[8])
      else $error("link flag set without event");
   AST_LINK_ZERO_KEEP: assert property (s_stat_wr ##0 !cfg_wdata[8]
      && slot_event_status[8] |=> slot_event_status[8])
      else $error("zero write cleared link flag");
   AST_STAT_SPARE: assert property ((slot_event_status
      & ~phsr_pkg::STAT_W1C_MASK) == 16'h0000)
      else $error("spare status bit stored");

   AST_SET_WINS: assert property (s_w1c(0) ##0 evt.button_press
      |=> slot_event_status[0])
      else $error("event lost against clear");
   AST_ZERO_KEEP: assert property (s_stat_wr ##0 !cfg_wdata[1]
      && slot_event_status[1] |=> slot_event_status[1])
      else $error("zero write cleared a flag");
   AST_BUTTON_IRQ: assert property (slot_event_status[0]
      && slot_control[0] && slot_control[5] |=> slot_irq)
      else $error("button interrupt missing");

   // interrupt per enabled fault, presence, command and link flag, none without an enabled flag
   AST_FAULT_IRQ: assert property (slot_event_status[1]
      && slot_control[1] && slot_control[5] |=> slot_irq)
      else $error("power fault interrupt missing");
   AST_PRESENCE_IRQ: assert property (slot_event_status[3]
      && slot_control[3] && slot_control[5] |=> slot_irq)
      else $error("presence interrupt missing");
   AST_CMD_IRQ: assert property (slot_event_status[4]
      && slot_control[4] && slot_control[5] |=> slot_irq)
      else $error("command interrupt missing");
   AST_LINK_IRQ: assert property (slot_event_status[8]
      && slot_control[12] && slot_control[5] |=> slot_irq)
      else $error("link interrupt missing");
   AST_NO_CAUSE: assert property ((slot_event_status & enable_vec)
      == 16'h0000 |=> !slot_irq)
      else $error("interrupt with no enabled flag");

   AST_MASTER_OFF: assert property (!slot_control[5] |=> !slot_irq)
      else $error("interrupt without master enable");
   AST_LINK_GATE: assert property (slot_event_status == 16'h0100
      && !slot_control[12] |=> !slot_irq)
      else $error("link interrupt while disabled");
   AST_IRQ_CAUSE: assert property (slot_irq |-> $past(slot_control[5]
      && |(slot_event_status & enable_vec)))
      else $error("interrupt without cause");
   AST_ALERT_OFF: assert property (slot_control[7:6] == 2'h3
      |=> !alert_lamp_on && !alert_lamp_blink)
      else $error("alert lamp not off");
   AST_POWER_LAMP: assert property (slot_control[9:8] == 2'h1
      |=> power_lamp_on)
      else $error("power lamp not on");
   AST_POWER: assert property (##1 slot_power_en
      == !$past(slot_control[10]))
      else $error("slot power does not follow control");
   AST_INTERLOCK: assert property (##1 interlock_engage
      == $past(slot_control[11]))
      else $error("interlock does not follow control");

   // lamp codes, slot power and interlock levels
   AST_ALERT_BLINK: assert property (slot_control[7:6] == 2'h2
      |=> alert_lamp_blink && !alert_lamp_on)
      else $error("alert lamp not blinking");
   AST_POWER_SOLID: assert property (slot_control[9:8] == 2'h1
      |=> !power_lamp_blink)
      else $error("power lamp blinking when on");
   AST_POWER_ON: assert property (!slot_control[10]
      |=> slot_power_en)
      else $error("slot power not applied");
   AST_POWER_OFF: assert property (slot_control[10]
      |=> !slot_power_en)
      else $error("slot power not removed");
   AST_LOCK: assert property (slot_control[11]
      |=> interlock_engage)
      else $error("interlock not locked");
   AST_UNLOCK: assert property (!slot_control[11]
      |=> !interlock_engage)
      else $error("interlock not released");

   AST_CTRL_WRITE: assert property (s_ctrl_wr ##0 cfg_be == 2'h3
      ##0 cfg_wdata[10] |=> slot_control[10] ##1 !slot_power_en)
      else $error("power off write not applied");
   AST_PRESENT_READ: assert property (cfg_rd_en
      && cfg_addr == phsr_pkg::STAT_OFFSET
      |=> cfg_rd_valid && cfg_rdata[6] == $past(evt.presence_state))
      else $error("presence bit misreported");

   // read answer timing and unmapped reads
   AST_RD_VALID: assert property (cfg_rd_en |=> cfg_rd_valid)
      else $error("read answer missing");
   AST_RD_IDLE: assert property (!cfg_rd_en
      |=> !cfg_rd_valid && cfg_rdata == 16'h0000)
      else $error("read answer without request");
   AST_UNMAPPED_READ: assert property (cfg_rd_en
      && cfg_addr != phsr_pkg::CTRL_OFFSET
      && cfg_addr != phsr_pkg::STAT_OFFSET |=> cfg_rdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule // phsr_regs

// [tb/phsr_slot_model.sv]
// behavioural hot-plug slot: button, fault, latch, presence, command, link
// assumes one-cycle requests from the bench on ref_clk
`timescale 1ns/1ps
module phsr_slot_model #(
   parameter int HOLD_CYC = 4
) (
   input wire logic ref_clk,
   input wire logic [5:0] ev_req,
   output logic attn_button_pin,
   output logic power_fault_pin,
   output logic latch_open_pin,
   output logic presence_pin,
   output logic cmd_done_pin,
   output logic link_active
);
   // pulse pins stay high HOLD_CYC cycles; level pins toggle per request
   logic [5:0] lvl = 6'h00;
   int cnt [6] = '{default: 0};

   always @(posedge ref_clk) begin
      for (int i = 0; i < 6; i++) begin
         if (ev_req[i]) begin
            lvl[i] <= (i == 2 || i == 3 || i == 5) ? !lvl[i] : 1'b1;
            cnt[i] <= HOLD_CYC;
         end else if (cnt[i] == 1) begin
            if (!(i == 2 || i == 3 || i == 5)) lvl[i] <= 1'b0;
            cnt[i] <= 0;
         end else if (cnt[i] > 0) begin
            cnt[i] <= cnt[i] - 1;
         end
      end
   end

   assign attn_button_pin = lvl[0];
   assign power_fault_pin = lvl[1];
   assign latch_open_pin = lvl[2];
   assign presence_pin = lvl[3];
   assign cmd_done_pin = lvl[4];
   assign link_active = lvl[5];
endmodule // phsr_slot_model

// [tb/tb_top.sv]
// self-checking bench for the hot-plug slot register block
// assumes phsr_pkg, phsr_regs and the slot model are compiled first
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] ctrl_a = phsr_pkg::CTRL_OFFSET;
   localparam logic [7:0] stat_a = phsr_pkg::STAT_OFFSET;
   logic ref_clk, reset_n, cfg_wr_en, cfg_rd_en, cfg_rd_valid;
   logic [7:0] cfg_addr;
   logic [1:0] cfg_be;
   logic [15:0] cfg_wdata, cfg_rdata, ctrl, flags, q;
   logic attn_button_pin, power_fault_pin, latch_open_pin, presence_pin;
   logic cmd_done_pin, link_active, alert_lamp_on, alert_lamp_blink;
   logic power_lamp_on, power_lamp_blink, slot_power_en, interlock_engage;
   logic slot_irq, lat, pres;
   logic [5:0] ev_req;
   logic [15:0] lfsr = 16'he234;
   int err_count = 0;
   int checked = 0;
   int fbit [6] = '{0, 1, 2, 3, 4, 8};
   logic [15:0] enb [6] = '{16'h1, 16'h2, 16'h4, 16'h8, 16'h10, 16'h1000};
   logic [15:0] ack [10] = '{16'h0401, 16'h0403, 16'h040b, 16'h041b,
      16'h043b, 16'h04fb, 16'h05fb, 16'h01fb, 16'h09fb, 16'h19fb};

   phsr_regs DUT (.ref_clk(ref_clk), .reset_n(reset_n), .cfg_addr(cfg_addr),
      .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_rd_valid(cfg_rd_valid), .attn_button_pin(attn_button_pin),
      .power_fault_pin(power_fault_pin), .latch_open_pin(latch_open_pin),
      .presence_pin(presence_pin), .cmd_done_pin(cmd_done_pin),
      .link_active(link_active), .alert_lamp_on(alert_lamp_on),
      .alert_lamp_blink(alert_lamp_blink), .power_lamp_on(power_lamp_on),
      .power_lamp_blink(power_lamp_blink), .slot_power_en(slot_power_en),
      .interlock_engage(interlock_engage), .slot_irq(slot_irq));

   phsr_slot_model #(.HOLD_CYC(4)) slot (.ref_clk(ref_clk), .ev_req(ev_req),
      .attn_button_pin(attn_button_pin), .power_fault_pin(power_fault_pin),
      .latch_open_pin(latch_open_pin), .presence_pin(presence_pin),
      .cmd_done_pin(cmd_done_pin), .link_active(link_active));

   function automatic logic [15:0] next_rand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [1:0] be,
      input logic [15:0] d);
      logic [15:0] m;
      m = {{8{be[1]}}, {8{be[0]}}};
      @(posedge ref_clk);
      cfg_addr <= a;
      cfg_be <= be;
      cfg_wdata <= d;
      cfg_wr_en <= 1'b1;
      @(posedge ref_clk);
      cfg_wr_en <= 1'b0;
      if (a == ctrl_a) ctrl = (ctrl & ~m) | (d & m & phsr_pkg::CTRL_WR_MASK);
      if (a == stat_a) flags = flags & ~(d & m & phsr_pkg::STAT_W1C_MASK);
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] r);
      int n;
      @(posedge ref_clk);
      cfg_addr <= a;
      cfg_rd_en <= 1'b1;
      @(posedge ref_clk);
      cfg_rd_en <= 1'b0;
      n = 0;
      #1;
      while (cfg_rd_valid !== 1'b1 && n < 4) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (cfg_rd_valid !== 1'b1) begin
         err_count++;
         give_verdict();
      end
      r = cfg_rdata;
   endtask

   task automatic fire(input int k);
      @(posedge ref_clk);
      ev_req <= 6'(1 << k);
      @(posedge ref_clk);
      ev_req <= 6'h00;
      repeat (10) @(posedge ref_clk);
      flags[fbit[k]] = 1'b1;
      if (k == 2) lat = !lat;
      if (k == 3) pres = !pres;
   endtask

   // clear write taken at the very edge that the pin event sets the flag
   task automatic fire_clr(input int k);
      @(posedge ref_clk);
      ev_req <= 6'(1 << k);
      @(posedge ref_clk);
      ev_req <= 6'h00;
      @(posedge ref_clk);
      @(posedge ref_clk);
      cfg_addr <= stat_a;
      cfg_be <= 2'h3;
      cfg_wdata <= 16'h0001 << fbit[k];
      cfg_wr_en <= 1'b1;
      @(posedge ref_clk);
      cfg_wr_en <= 1'b0;
      repeat (10) @(posedge ref_clk);
      flags[fbit[k]] = 1'b1;
   endtask

   task automatic check_all();
      logic [15:0] g, e;
      rd(ctrl_a, g);
      cmp(g, ctrl);
      rd(stat_a, g);
      cmp(g, flags | {9'h000, pres, lat, 5'h00});
      g = {10'h000, alert_lamp_on, alert_lamp_blink, power_lamp_on,
         power_lamp_blink, slot_power_en, interlock_engage};
      e = {10'h000, ctrl[7:6] == 2'h1, ctrl[7:6] == 2'h2,
         ctrl[9:8] == 2'h1, ctrl[9:8] == 2'h2, !ctrl[10], ctrl[11]};
      cmp(g, e);
      e = {15'h0000, ctrl[5] & (|(flags[4:0] & ctrl[4:0]) |
         (flags[8] & ctrl[12]))};
      cmp({15'h0000, slot_irq}, e);
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (60000) @(posedge ref_clk);
      err_count++;
      give_verdict();
   end

   initial begin
      reset_n = 1'b0;
      cfg_addr = 8'h00;
      cfg_wr_en = 1'b0;
      cfg_rd_en = 1'b0;
      cfg_be = 2'h0;
      cfg_wdata = 16'h0000;
      ev_req = 6'h00;
      ctrl = phsr_pkg::CTRL_RESET;
      flags = 16'h0000;
      lat = 1'b0;
      pres = 1'b0;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check_all();
      for (int m = 0; m < 2; m++) begin
         for (int k = 0; k < 6; k++) begin
            lfsr = next_rand(lfsr);
            q = (lfsr & 16'hffdf) | enb[k] | (m == 1 ? 16'h0020 : 16'h0000);
            wr(ctrl_a, 2'h3, q);
            fire(k);
            check_all();
            wr(stat_a, 2'h3, 16'h0000);
            check_all();
            wr(stat_a, 2'h3, 16'h0001 << fbit[k]);
            check_all();
         end
      end
      for (int k = 0; k < 4; k++) begin
         wr(ctrl_a, 2'h3, 16'(k * 16'h0540));
         check_all();
      end
      fire(5);
      wr(stat_a, 2'h1, 16'hffff);
      check_all();
      wr(stat_a, 2'h2, 16'hffff);
      check_all();
      rd(8'h74, q);
      cmp(q, 16'h0000);
      wr(8'h71, 2'h3, 16'hffff);
      check_all();
      fire(0);
      fire(4);
      fire_clr(0);
      check_all();
      wr(stat_a, 2'h3, 16'h011f);
      for (int i = 0; i < 10; i++) begin
         wr(ctrl_a, 2'h3, ack[i]);
         check_all();
      end
      fire(3);
      check_all();
      reset_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      ctrl = phsr_pkg::CTRL_RESET;
      flags = 16'h0000;
      repeat (4) @(posedge ref_clk);
      check_all();
      give_verdict();
   end
endmodule // tb_top
